// *** rtl/mus_top.sv ***
// Purpose: Motion unit scaling configuration bank behind an APB slave
// Assumes: APB3 master, zero-wait access, 32-bit words at index*4
// Notes: Unmapped access and writes to the availability map give pslverr
`timescale 1ns/1ps
module mus_top #(
    parameter int unsigned CYCLES_PER_MS = mus_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [15:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    // Motor data
    input wire logic [7:0] I_POLE_PAIRS,
    // Configuration outputs
    output logic O_PULSE_CW_CCW,
    output logic O_POLE_COMP_EN,
    output logic [31:0] O_SPEED_NUM,
    output logic [31:0] O_SPEED_DEN,
    output logic [31:0] O_ACCEL_NUM,
    output logic [31:0] O_ACCEL_DEN,
    output logic [31:0] O_JERK_NUM,
    output logic [31:0] O_JERK_DEN,
    output logic [2:0] O_SCALE_DEN_BAD,
    output logic [31:0] O_FBUS_ENABLE,
    output logic O_READY
);
    logic [31:0] mode_ff, nxt_mode;
    logic [31:0] comp_ff, nxt_comp;
    logic [31:0] snum_ff, nxt_snum;
    logic [31:0] sden_ff, nxt_sden;
    logic [31:0] anum_ff, nxt_anum;
    logic [31:0] aden_ff, nxt_aden;
    logic [31:0] jnum_ff, nxt_jnum;
    logic [31:0] jden_ff, nxt_jden;
    logic [31:0] boot_ff, nxt_boot;
    logic [31:0] fbc_ff, nxt_fbc;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;
    logic setup;
    logic access;
    logic bad_req;
    logic wr_en;
    logic comp_en;

    function automatic logic is_mapped(input logic [15:0] addr);
        is_mapped = (addr == mus_pkg::ADDR_PULSE_MODE) || (addr == mus_pkg::ADDR_POLE_COMP)
            || (addr == mus_pkg::ADDR_SPEED_NUM) || (addr == mus_pkg::ADDR_SPEED_DEN)
            || (addr == mus_pkg::ADDR_ACCEL_NUM) || (addr == mus_pkg::ADDR_ACCEL_DEN)
            || (addr == mus_pkg::ADDR_JERK_NUM) || (addr == mus_pkg::ADDR_JERK_DEN)
            || (addr == mus_pkg::ADDR_BOOT_DELAY) || (addr == mus_pkg::ADDR_AVAIL_MAP)
            || (addr == mus_pkg::ADDR_FBUS_CTRL);
    endfunction : is_mapped

    // Zero-wait slave: read data is caught at setup so it leaves a flip-flop
    assign setup = I_PSEL && !I_PENABLE;
    assign access = I_PSEL && I_PENABLE;
    assign bad_req = !is_mapped(I_PADDR)
        || (I_PWRITE && I_PADDR == mus_pkg::ADDR_AVAIL_MAP);
    assign wr_en = access && I_PWRITE && !bad_req;

    // Register writes
    always_comb begin
        nxt_mode = mode_ff;
        nxt_comp = comp_ff;
        nxt_snum = snum_ff;
        nxt_sden = sden_ff;
        nxt_anum = anum_ff;
        nxt_aden = aden_ff;
        nxt_jnum = jnum_ff;
        nxt_jden = jden_ff;
        nxt_boot = boot_ff;
        nxt_fbc = fbc_ff;
        if (wr_en) begin
            unique case (I_PADDR)
                mus_pkg::ADDR_PULSE_MODE: nxt_mode = I_PWDATA;
                mus_pkg::ADDR_POLE_COMP: nxt_comp = I_PWDATA;
                mus_pkg::ADDR_SPEED_NUM: nxt_snum = I_PWDATA;
                mus_pkg::ADDR_SPEED_DEN: nxt_sden = I_PWDATA;
                mus_pkg::ADDR_ACCEL_NUM: nxt_anum = I_PWDATA;
                mus_pkg::ADDR_ACCEL_DEN: nxt_aden = I_PWDATA;
                mus_pkg::ADDR_JERK_NUM: nxt_jnum = I_PWDATA;
                mus_pkg::ADDR_JERK_DEN: nxt_jden = I_PWDATA;
                mus_pkg::ADDR_BOOT_DELAY: nxt_boot = I_PWDATA;
                mus_pkg::ADDR_FBUS_CTRL: nxt_fbc = I_PWDATA;
                default: nxt_mode = mode_ff;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            mode_ff <= mus_pkg::RST_PULSE_MODE;
            comp_ff <= mus_pkg::RST_POLE_COMP;
            snum_ff <= mus_pkg::RST_SCALE_NUM;
            sden_ff <= mus_pkg::RST_SCALE_DEN;
            anum_ff <= mus_pkg::RST_SCALE_NUM;
            aden_ff <= mus_pkg::RST_SCALE_DEN;
            jnum_ff <= mus_pkg::RST_SCALE_NUM;
            jden_ff <= mus_pkg::RST_SCALE_DEN;
            boot_ff <= mus_pkg::RST_BOOT_DELAY;
            fbc_ff <= mus_pkg::RST_FBUS_CTRL;
        end else begin
            mode_ff <= nxt_mode;
            comp_ff <= nxt_comp;
            snum_ff <= nxt_snum;
            sden_ff <= nxt_sden;
            anum_ff <= nxt_anum;
            aden_ff <= nxt_aden;
            jnum_ff <= nxt_jnum;
            jden_ff <= nxt_jden;
            boot_ff <= nxt_boot;
            fbc_ff <= nxt_fbc;
        end
    end

    // Read path and error answer
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        if (setup) begin
            nxt_err = bad_req;
            unique case (I_PADDR)
                mus_pkg::ADDR_PULSE_MODE: nxt_rdata = mode_ff;
                mus_pkg::ADDR_POLE_COMP: nxt_rdata = comp_ff;
                mus_pkg::ADDR_SPEED_NUM: nxt_rdata = snum_ff;
                mus_pkg::ADDR_SPEED_DEN: nxt_rdata = sden_ff;
                mus_pkg::ADDR_ACCEL_NUM: nxt_rdata = anum_ff;
                mus_pkg::ADDR_ACCEL_DEN: nxt_rdata = aden_ff;
                mus_pkg::ADDR_JERK_NUM: nxt_rdata = jnum_ff;
                mus_pkg::ADDR_JERK_DEN: nxt_rdata = jden_ff;
                mus_pkg::ADDR_BOOT_DELAY: nxt_rdata = boot_ff;
                mus_pkg::ADDR_AVAIL_MAP: nxt_rdata = mus_pkg::RST_AVAIL_MAP;
                mus_pkg::ADDR_FBUS_CTRL: nxt_rdata = fbc_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    assign O_PREADY = access;
    assign O_PSLVERR = err_ff && access;
    assign O_PRDATA = rdata_ff;

    // Mode decode; undefined codes fall back to step/direction
    assign O_PULSE_CW_CCW = (mode_ff == mus_pkg::MODE_CW_CCW);
    assign comp_en = (comp_ff == mus_pkg::COMP_ON);
    assign O_POLE_COMP_EN = comp_en;
    assign O_FBUS_ENABLE = fbc_ff;

    mus_scale_pair u_speed (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_num(snum_ff),
        .i_den(sden_ff),
        .i_comp_en(comp_en),
        .i_pole_pairs(I_POLE_PAIRS),
        .o_eff_num(O_SPEED_NUM),
        .o_den(O_SPEED_DEN),
        .o_den_bad(O_SCALE_DEN_BAD[0])
    );

    mus_scale_pair u_accel (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_num(anum_ff),
        .i_den(aden_ff),
        .i_comp_en(comp_en),
        .i_pole_pairs(I_POLE_PAIRS),
        .o_eff_num(O_ACCEL_NUM),
        .o_den(O_ACCEL_DEN),
        .o_den_bad(O_SCALE_DEN_BAD[1])
    );

    mus_scale_pair u_jerk (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_num(jnum_ff),
        .i_den(jden_ff),
        .i_comp_en(comp_en),
        .i_pole_pairs(I_POLE_PAIRS),
        .o_eff_num(O_JERK_NUM),
        .o_den(O_JERK_DEN),
        .o_den_bad(O_SCALE_DEN_BAD[2])
    );

    mus_boot_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_boot (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_delay_ms(boot_ff),
        .o_ready(O_READY)
    );

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    property p_mode_write;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_PULSE_MODE
            |=> mode_ff == $past(I_PWDATA);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not stored");

    property p_mode_pin;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_PULSE_MODE
            |=> O_PULSE_CW_CCW == ($past(I_PWDATA) == mus_pkg::MODE_CW_CCW);
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("mode pin wrong");

    property p_avail_read;
        setup && !I_PWRITE && I_PADDR == mus_pkg::ADDR_AVAIL_MAP
            ##1 access |-> O_PRDATA == mus_pkg::RST_AVAIL_MAP && !O_PSLVERR;
    endproperty
    a_avail_read: assert property (p_avail_read) else $error("avail read wrong");

    property p_avail_ro;
        setup && I_PWRITE && I_PADDR == mus_pkg::ADDR_AVAIL_MAP ##1 access |-> O_PSLVERR;
    endproperty
    a_avail_ro: assert property (p_avail_ro) else $error("avail write accepted");

    // Applied value lags the bank by one edge, so compare with last cycle's inputs
    property p_comp_speed;
        comp_en && sden_ff != 32'h0000_0000
            |=> O_SPEED_NUM == 32'($past(snum_ff) * $past(I_POLE_PAIRS));
    endproperty
    a_comp_speed: assert property (p_comp_speed) else $error("pole pairs ignored");

    property p_fbus_ctrl;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_FBUS_CTRL
            |=> O_FBUS_ENABLE == $past(I_PWDATA);
    endproperty
    a_fbus_ctrl: assert property (p_fbus_ctrl) else $error("fbus ctrl not stored");

    property p_speed_write;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_SPEED_NUM
            |=> snum_ff == $past(I_PWDATA);
    endproperty
    a_speed_write: assert property (p_speed_write) else $error("speed num not stored");

    property p_accel_write;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_ACCEL_NUM
            |=> anum_ff == $past(I_PWDATA);
    endproperty
    a_accel_write: assert property (p_accel_write) else $error("accel num not stored");

    property p_jerk_write;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_JERK_DEN
            |=> jden_ff == $past(I_PWDATA);
    endproperty
    a_jerk_write: assert property (p_jerk_write) else $error("jerk den not stored");

    property p_comp_pin;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_POLE_COMP
            |=> O_POLE_COMP_EN == ($past(I_PWDATA) == mus_pkg::COMP_ON);
    endproperty
    a_comp_pin: assert property (p_comp_pin) else $error("comp enable wrong");

    property p_comp_off;
        !comp_en && jden_ff != 32'h0000_0000
            |=> O_JERK_NUM == $past(jnum_ff);
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("pole pairs applied");

    property p_avail_proto;
        setup && !I_PWRITE && I_PADDR == mus_pkg::ADDR_AVAIL_MAP
            ##1 access |-> O_PRDATA[31:16] == mus_pkg::RST_AVAIL_MAP[31:16];
    endproperty
    a_avail_proto: assert property (p_avail_proto) else $error("protocol half wrong");

    property p_boot_write;
        access && I_PWRITE && I_PADDR == mus_pkg::ADDR_BOOT_DELAY
            |=> boot_ff == $past(I_PWDATA);
    endproperty
    a_boot_write: assert property (p_boot_write) else $error("boot delay not stored");

    c_avail_read: cover property (setup && !I_PWRITE && I_PADDR == mus_pkg::ADDR_AVAIL_MAP);
    c_err: cover property (O_PSLVERR);
    c_cw_ccw: cover property ($rose(O_PULSE_CW_CCW));
endmodule : mus_top

// *** rtl/mus_pkg.sv ***
// Purpose: Shared constants of the motion unit scaling configuration bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are register indices; byte address is four times the index
package mus_pkg;
    localparam int unsigned ADDR_W = 16;

    // Register indices as printed
    localparam logic [15:0] IDX_PULSE_MODE = 16'h205b;
    localparam logic [15:0] IDX_POLE_COMP = 16'h2060;
    localparam logic [15:0] IDX_SPEED_NUM = 16'h2061;
    localparam logic [15:0] IDX_SPEED_DEN = 16'h2062;
    localparam logic [15:0] IDX_ACCEL_NUM = 16'h2063;
    localparam logic [15:0] IDX_ACCEL_DEN = 16'h2064;
    localparam logic [15:0] IDX_JERK_NUM = 16'h2065;
    localparam logic [15:0] IDX_JERK_DEN = 16'h2066;
    localparam logic [15:0] IDX_BOOT_DELAY = 16'h2084;
    localparam logic [15:0] IDX_AVAIL_MAP = 16'h2101;
    localparam logic [15:0] IDX_FBUS_CTRL = 16'h2102;

    // Byte addresses
    localparam logic [15:0] ADDR_PULSE_MODE = 16'(IDX_PULSE_MODE * 4);
    localparam logic [15:0] ADDR_POLE_COMP = 16'(IDX_POLE_COMP * 4);
    localparam logic [15:0] ADDR_SPEED_NUM = 16'(IDX_SPEED_NUM * 4);
    localparam logic [15:0] ADDR_SPEED_DEN = 16'(IDX_SPEED_DEN * 4);
    localparam logic [15:0] ADDR_ACCEL_NUM = 16'(IDX_ACCEL_NUM * 4);
    localparam logic [15:0] ADDR_ACCEL_DEN = 16'(IDX_ACCEL_DEN * 4);
    localparam logic [15:0] ADDR_JERK_NUM = 16'(IDX_JERK_NUM * 4);
    localparam logic [15:0] ADDR_JERK_DEN = 16'(IDX_JERK_DEN * 4);
    localparam logic [15:0] ADDR_BOOT_DELAY = 16'(IDX_BOOT_DELAY * 4);
    localparam logic [15:0] ADDR_AVAIL_MAP = 16'(IDX_AVAIL_MAP * 4);
    localparam logic [15:0] ADDR_FBUS_CTRL = 16'(IDX_FBUS_CTRL * 4);

    // Reset values
    localparam logic [31:0] RST_PULSE_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_POLE_COMP = 32'h0000_0001;
    localparam logic [31:0] RST_SCALE_NUM = 32'h0000_0001;
    localparam logic [31:0] RST_SCALE_DEN = 32'h0000_003c;
    localparam logic [31:0] RST_BOOT_DELAY = 32'h0000_0000;
    localparam logic [31:0] RST_AVAIL_MAP = 32'h0019_0001;
    localparam logic [31:0] RST_FBUS_CTRL = 32'h0008_0001;

    // Field values and positions
    localparam logic [31:0] MODE_STEP_DIR = 32'h0000_0000;
    localparam logic [31:0] MODE_CW_CCW = 32'h0000_0001;
    localparam logic [31:0] COMP_ON = 32'h0000_0001;
    localparam int unsigned AVAIL_IF_LSB = 0;
    localparam int unsigned AVAIL_PROTO_LSB = 16;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned BOOT_UNIT_NS = 1000000;
    localparam int unsigned CYCLES_PER_MS = BOOT_UNIT_NS / CLK_PERIOD_NS;
endpackage : mus_pkg

// *** rtl/mus_scale_pair.sv ***
// Purpose: Applied numerator/denominator pair with pole-pair factoring
// Assumes: Denominator zero is never applied
// Notes: Outputs lag the register bank by one cycle
`timescale 1ns/1ps
module mus_scale_pair (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Programmed values
    input wire logic [31:0] i_num,
    input wire logic [31:0] i_den,
    input wire logic i_comp_en,
    input wire logic [7:0] i_pole_pairs,
    // Applied values
    output logic [31:0] o_eff_num,
    output logic [31:0] o_den,
    output logic o_den_bad
);
    logic [31:0] num_ff, nxt_num;
    logic [31:0] den_ff, nxt_den;
    logic bad_ff, nxt_bad;
    logic [39:0] prod;

    always_comb begin
        prod = i_num * {32'h0000_0000, i_pole_pairs};
        nxt_bad = (i_den == 32'h0000_0000);
        nxt_num = num_ff;
        nxt_den = den_ff;
        // A zero divisor keeps the last good factor
        if (!nxt_bad) begin
            nxt_den = i_den;
            nxt_num = i_comp_en ? prod[31:0] : i_num;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            num_ff <= mus_pkg::RST_SCALE_NUM;
            den_ff <= mus_pkg::RST_SCALE_DEN;
            bad_ff <= 1'b0;
        end else begin
            num_ff <= nxt_num;
            den_ff <= nxt_den;
            bad_ff <= nxt_bad;
        end
    end

    assign o_eff_num = num_ff;
    assign o_den = den_ff;
    assign o_den_bad = bad_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_zero_den_hold;
        i_den == 32'h0000_0000 |=> o_den == $past(o_den) && o_den_bad;
    endproperty
    a_zero_den_hold: assert property (p_zero_den_hold) else $error("zero den applied");

    property p_den_apply;
        i_den != 32'h0000_0000 |=> o_den == $past(i_den);
    endproperty
    a_den_apply: assert property (p_den_apply) else $error("den not applied");

    property p_no_comp;
        !i_comp_en && i_den != 32'h0000_0000 |=> o_eff_num == $past(i_num);
    endproperty
    a_no_comp: assert property (p_no_comp) else $error("num altered w/o comp");

    c_zero_den: cover property (i_den == 32'h0000_0000 ##1 i_den != 32'h0000_0000);
endmodule : mus_scale_pair

// *** rtl/mus_boot_timer.sv ***
// Purpose: Holds readiness off for the programmed number of milliseconds
// Assumes: Counting starts at release of reset
// Notes: Ready latches; later delay writes do not withdraw it
`timescale 1ns/1ps
module mus_boot_timer #(
    parameter int unsigned CYCLES_PER_MS = mus_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Delay and status
    input wire logic [31:0] i_delay_ms,
    output logic o_ready
);
    typedef enum logic {MUSB_WAIT = 1'b0, MUSB_READY = 1'b1} musb_state_t;
    musb_state_t state_ff, nxt_state;
    logic [31:0] tick_ff, nxt_tick;
    logic [31:0] ms_ff, nxt_ms;

    always_comb begin
        nxt_state = state_ff;
        nxt_tick = tick_ff;
        nxt_ms = ms_ff;
        unique case (state_ff)
            MUSB_WAIT: begin
                if (ms_ff >= i_delay_ms) begin
                    nxt_state = MUSB_READY;
                end else if (tick_ff == 32'(CYCLES_PER_MS - 1)) begin
                    nxt_tick = 32'h0000_0000;
                    nxt_ms = ms_ff + 32'h0000_0001;
                end else begin
                    nxt_tick = tick_ff + 32'h0000_0001;
                end
            end
            MUSB_READY: begin
                nxt_state = MUSB_READY;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= MUSB_WAIT;
            tick_ff <= 32'h0000_0000;
            ms_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            tick_ff <= nxt_tick;
            ms_ff <= nxt_ms;
        end
    end

    assign o_ready = (state_ff == MUSB_READY);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_ready_after_delay;
        $rose(o_ready) |-> $past(ms_ff) >= $past(i_delay_ms);
    endproperty
    a_ready_after_delay: assert property (p_ready_after_delay) else $error("ready early");

    property p_ready_sticks;
        o_ready |=> o_ready;
    endproperty
    a_ready_sticks: assert property (p_ready_sticks) else $error("ready dropped");

    c_ready: cover property ($rose(o_ready));
endmodule : mus_boot_timer

// *** dv/mus_top_tb.sv ***
// Purpose: Self-checking bench for the scaling configuration bank over APB
// Assumes: Zero-wait APB slave; ms counter shortened to CPM cycles
// Notes: Random data from an LFSR; outputs compared against a queue-free integer model
`timescale 1ns/1ps
module mus_top_tb;
    localparam int unsigned CPM = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] pp = 8'h03;
    logic pready, pslverr, cw_ccw, comp_en, ready;
    logic [31:0] prdata, fbus;
    logic [2:0] den_bad;
    logic [31:0] num_o[3];
    logic [31:0] den_o[3];
    logic [31:0] mdl [logic [15:0]];
    logic [31:0] ap_num[3];
    logic [31:0] ap_den[3];
    logic [31:0] rnd = 32'h0001_08ec;
    int n_mismatch = 0;
    int checks = 0;
    logic [15:0] all_a[11] = '{mus_pkg::ADDR_PULSE_MODE, mus_pkg::ADDR_POLE_COMP,
        mus_pkg::ADDR_SPEED_NUM, mus_pkg::ADDR_SPEED_DEN, mus_pkg::ADDR_ACCEL_NUM,
        mus_pkg::ADDR_ACCEL_DEN, mus_pkg::ADDR_JERK_NUM, mus_pkg::ADDR_JERK_DEN,
        mus_pkg::ADDR_BOOT_DELAY, mus_pkg::ADDR_AVAIL_MAP, mus_pkg::ADDR_FBUS_CTRL};
    logic [31:0] all_r[11] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_003c,
        32'h0000_0001, 32'h0000_003c, 32'h0000_0001, 32'h0000_003c, 32'h0000_0000,
        32'h0019_0001, 32'h0008_0001};
    logic [15:0] num_a[3] = '{mus_pkg::ADDR_SPEED_NUM, mus_pkg::ADDR_ACCEL_NUM,
        mus_pkg::ADDR_JERK_NUM};
    logic [15:0] den_a[3] = '{mus_pkg::ADDR_SPEED_DEN, mus_pkg::ADDR_ACCEL_DEN,
        mus_pkg::ADDR_JERK_DEN};

    always #10 clk = ~clk;

    mus_top #(.CYCLES_PER_MS(CPM)) DUT (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_POLE_PAIRS(pp),
        .O_PULSE_CW_CCW(cw_ccw), .O_POLE_COMP_EN(comp_en), .O_SPEED_NUM(num_o[0]),
        .O_SPEED_DEN(den_o[0]), .O_ACCEL_NUM(num_o[1]), .O_ACCEL_DEN(den_o[1]),
        .O_JERK_NUM(num_o[2]), .O_JERK_DEN(den_o[2]), .O_SCALE_DEN_BAD(den_bad),
        .O_FBUS_ENABLE(fbus), .O_READY(ready)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction : lfsr

    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Master holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 32'h1, 32'h0);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Unmapped places and the availability map refuse writes with an error
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        logic ok;
        ok = mdl.exists(a) && !(wr && a == mus_pkg::ADDR_AVAIL_MAP);
        apb(wr, a, d, rd, er);
        chk("pslverr", {31'h0, !ok}, {31'h0, er});
        if (wr && ok) begin
            mdl[a] = d;
        end
        if (!wr) begin
            chk("prdata", mdl.exists(a) ? mdl[a] : 32'h0, rd);
        end
    endtask : access

    // Scaled outputs follow a write by two edges; mode, comp and fbus outputs by one
    task automatic check_outputs();
        logic comp;
        comp = mdl[mus_pkg::ADDR_POLE_COMP] == 32'h1;
        repeat (3) @(posedge clk);
        #1;
        chk("cw_ccw", {31'h0, mdl[mus_pkg::ADDR_PULSE_MODE] == 32'h1}, {31'h0, cw_ccw});
        chk("comp_en", {31'h0, comp}, {31'h0, comp_en});
        chk("fbus", mdl[mus_pkg::ADDR_FBUS_CTRL], fbus);
        chk("ready", 32'h1, {31'h0, ready});
        for (int i = 0; i < 3; i++) begin
            if (mdl[den_a[i]] != 32'h0) begin
                ap_num[i] = comp ? 32'(mdl[num_a[i]] * pp) : mdl[num_a[i]];
                ap_den[i] = mdl[den_a[i]];
            end
            chk("num", ap_num[i], num_o[i]);
            chk("den", ap_den[i], den_o[i]);
            chk("den_bad", {31'h0, mdl[den_a[i]] == 32'h0}, {31'h0, den_bad[i]});
        end
    endtask : check_outputs

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        for (int i = 0; i < 11; i++) begin
            mdl[all_a[i]] = all_r[i];
        end
        repeat (8) @(posedge clk);
        chk("ready_in_reset", 32'h0, {31'h0, ready});
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            access(1'b0, all_a[i], 32'h0);
        end
        check_outputs();
        // Mode codes and compensation settings, including an undefined code
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            rnd = lfsr(rnd);
            pp <= rnd[7:0];
            access(1'b1, mus_pkg::ADDR_PULSE_MODE, 32'(m));
            access(1'b1, mus_pkg::ADDR_POLE_COMP, 32'(m));
            check_outputs();
        end
        // Random traffic over every place, refused writes included
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 11; i++) begin
                rnd = lfsr(rnd);
                access(1'b1, all_a[i], rnd);
            end
            access(1'b1, mus_pkg::ADDR_POLE_COMP, 32'(r[0]));
            check_outputs();
            for (int i = 0; i < 11; i++) begin
                access(1'b0, all_a[i], 32'h0);
            end
        end
        // Zero denominator keeps the previous factor, even when the numerator moves
        for (int i = 0; i < 3; i++) begin
            access(1'b1, den_a[i], 32'h0);
            check_outputs();
            rnd = lfsr(rnd);
            access(1'b1, num_a[i], rnd);
            check_outputs();
            access(1'b1, den_a[i], 32'h0000_0005);
            check_outputs();
        end
        // Unmapped places read zero and refuse; fbus control and the availability map then read back without error
        access(1'b0, 16'h0000, 32'h0);
        access(1'b1, 16'h8400, 32'h1234_5678);
        access(1'b0, mus_pkg::ADDR_AVAIL_MAP + 16'h0004 + 16'h0004, 32'h0);
        access(1'b0, mus_pkg::ADDR_FBUS_CTRL, 32'h0);
        access(1'b0, mus_pkg::ADDR_AVAIL_MAP, 32'h0);
        give_verdict();
    end
endmodule : mus_top_tb
